// File: core/psmlc_pkg.sv
// constants, carriers and mode encodings of the strap, pin-mux and led block
package psmlc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int RESET_MIN_NS = 1000;
  localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] RESET_MIN_COUNT = 5'(RESET_MIN_CYCLES);
  localparam logic [4:0] RESET_CNT_INIT = 5'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] LED_OFFSET = 4'h8;

  // control fields
  localparam int CTRL_LED_BLANK_BIT = 0;
  localparam int CTRL_RATE_GATE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;

  // status fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_ADDR_LSB = 4;
  localparam int STAT_FORCE_FAST_BIT = 9;
  localparam int STAT_AUTONEG_EN_BIT = 10;
  localparam int STAT_COMBO_BIT = 11;
  localparam int STAT_SLAVE_LINK_BIT = 12;
  localparam int STAT_SCRAMBLE_BYP_BIT = 13;
  localparam int STAT_LOOPBACK_BIT = 14;
  localparam int STAT_RATE_GATE_BIT = 15;
  localparam int STAT_MAC_FLAVOUR_BIT = 16;

  // led fields
  localparam int LED_ACT_BIT = 0;
  localparam int LED_LINK_BIT = 1;
  localparam int LED_SPEED_BIT = 2;
  localparam int LED_FDX_LOW_BIT = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    PSMLC_MODE_ADAPTER = 2'b00,
    PSMLC_MODE_REPEATER = 2'b01,
    PSMLC_MODE_TEST = 2'b10
  } psmlc_mode_type;

  // pin inputs, asynchronous to the core clock
  typedef struct packed {
    logic repeater_select;
    logic test_enable;
    logic port_output_enable;
    logic force_fast_speed;
    logic [4:0] phy_addr;
    logic autoneg_disable;
    logic scramble_bypass;
    logic loopback_en;
    logic full_duplex_low;
    logic rx_congestion;
  } psmlc_pins_type;

  // status from the datapath, same clock
  typedef struct packed {
    logic tx_active;
    logic rx_active;
    logic link_valid;
    logic speed_fast;
    logic duplex_full;
    logic hcd_tx_fd;
    logic rate_permit;
    logic test_out_data;
  } psmlc_core_type;

  // avalon-mm slave request
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } psmlc_avs_req_type;

endpackage

// File: core/psmlc_sync.sv
// two flip-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module psmlc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] data_in,
  output logic [WIDTH-1:0] data_out
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta <= '0;
      data_out <= '0;
    end else begin
      meta <= data_in;
      data_out <= meta;
    end
  end

endmodule

// File: core/psmlc_top.sv
// strap decode, dual-function pin routing, flow-control gating and leds
// Behaviour
// - repeater select high gives repeater mode, low adapter mode; sets the address, speed, auto-negotiation, duplex, port-enable and congestion pin meanings
// - repeater mode with port enable low floats the receive outputs
// - test enable high switches shared pins to their test functions
// - in test, the transmit-ready pin carries test output data
// - in test, address bits 4, 1, 0 are test input, execute, clock
// - repeater mode takes the five-bit management address from strap pins
// - repeater mode forces 100 Mbps when force-speed is high, else 10 Mbps
// - adapter full duplex: same pin picks companion or generic mac flavour
// - repeater mode disables auto-negotiation while its disable strap, as loaded at the last mode change, is high
// - adapter mode with combo enable turns slave pins into slave handshake
// - adapter combo mode drives slave tristate active; slave then floats outputs
// - scramble bypass high bypasses scrambler and descrambler
// - loopback input high runs the diagnostic loopback
// - reset acts while asserted; pulse held at least 1 us
// - adapter mode drives full-duplex pin low for full duplex result
// - repeater reads full-duplex pin for advertisement; enables rate gating on tx fd
// - with rate gating outside test, transmit ready follows the permit to transmit
// - activity led on while transmit or receive activity is present
// - link led on while a valid link exists at 10 or 100 Mbps
// - speed led on at 100 Mbps, off at 10 Mbps
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module psmlc_top (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire psmlc_pkg::psmlc_pins_type pins_in,
  input wire psmlc_pkg::psmlc_core_type core_in,
  input wire psmlc_pkg::psmlc_avs_req_type avs_req_in,
  output logic avs_waitrequest_out,
  output logic [31:0] avs_readdata_out,
  output logic rx_output_enable_n_out,
  output logic tx_ready_gate_out,
  output logic test_in_out,
  output logic test_exec_out,
  output logic test_clk_out,
  output logic [4:0] phy_address_out,
  output logic force_speed_fast_out,
  output logic autoneg_enable_out,
  output logic mac_flavour_select_out,
  output logic combo_mode_out,
  output logic slave_tristate_out,
  output logic slave_tristate_oe_n_out,
  output logic slave_link_ok_out,
  output logic scramble_bypass_out,
  output logic loopback_en_out,
  output logic advertise_full_duplex_out,
  output logic rate_gate_enable_out,
  output logic rx_congestion_out,
  output logic full_duplex_low_out,
  output logic full_duplex_low_oe_n_out,
  output logic activity_led_out,
  output logic link_led_out,
  output logic speed_led_a_out
);
  import psmlc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // reset release and stretch

  logic reset_meta_n;
  logic reset_sync_n;
  logic [4:0] rst_cnt;
  logic core_rst_n;

  // two-flop release of the asynchronous reset
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reset_meta_n <= 1'b0;
      reset_sync_n <= 1'b0;
    end else begin
      reset_meta_n <= 1'b1;
      reset_sync_n <= reset_meta_n;
    end
  end

  // hold the core in reset for at least the minimum pulse width
  always_ff @(posedge core_clk_in or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      rst_cnt <= RESET_CNT_INIT;
      core_rst_n <= 1'b0;
    end else begin
      if (rst_cnt != RESET_MIN_COUNT) begin
        rst_cnt <= rst_cnt + 5'h01;
      end
      core_rst_n <= (rst_cnt == RESET_MIN_COUNT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and strap capture

  psmlc_pins_type pins_s;
  psmlc_pins_type cfg;
  logic cfg_valid;
  logic last_rpt;
  logic last_test;

  psmlc_sync #(
    .WIDTH($bits(psmlc_pins_type))
  ) u_pin_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(core_rst_n),
    .data_in(pins_in),
    .data_out(pins_s)
  );

  // reload when repeater or test select moves
  wire cfg_load = !cfg_valid || (pins_s.repeater_select != last_rpt) ||
                  (pins_s.test_enable != last_test);

  // strap snapshot held as configuration
  always_ff @(posedge core_clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      cfg <= '0;
      cfg_valid <= 1'b0;
      last_rpt <= 1'b0;
      last_test <= 1'b0;
    end else begin
      if (cfg_load) begin
        cfg <= pins_s;
      end
      cfg_valid <= 1'b1;
      last_rpt <= pins_s.repeater_select;
      last_test <= pins_s.test_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // mode decode

  psmlc_mode_type mode;
  wire psmlc_mode_type next_mode = cfg.test_enable ? PSMLC_MODE_TEST :
      (cfg.repeater_select ? PSMLC_MODE_REPEATER : PSMLC_MODE_ADAPTER);

  always_ff @(posedge core_clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      mode <= PSMLC_MODE_ADAPTER;
    end else begin
      mode <= next_mode;
    end
  end

  logic in_test;
  always_comb begin
    in_test = 1'b0;
    unique case (mode)
      PSMLC_MODE_ADAPTER: in_test = 1'b0;
      PSMLC_MODE_REPEATER: in_test = 1'b0;
      PSMLC_MODE_TEST: in_test = 1'b1;
      default: in_test = 1'b0;
    endcase
  end

  // repeater meaning holds outside test as well for non-test pins
  wire is_repeater = cfg.repeater_select;
  wire is_adapter = !cfg.repeater_select;

  ////////////////////////////////////////////////////////////////////////////////
  // control register and derived pin functions

  logic [1:0] ctrl;
  wire led_blank = ctrl[CTRL_LED_BLANK_BIT];
  wire rate_gate_sw = ctrl[CTRL_RATE_GATE_BIT];

  // combo handshake only in adapter mode
  wire combo = is_adapter && cfg.autoneg_disable;
  wire slave_link = combo && !pins_s.phy_addr[2];
  wire adv_fdx = is_repeater && !pins_s.full_duplex_low;
  wire mac_flavour = is_adapter && core_in.duplex_full && cfg.force_fast_speed;
  wire rate_gate = rate_gate_sw && (is_repeater ? (adv_fdx && core_in.hcd_tx_fd) :
                   (mac_flavour && core_in.duplex_full));
  wire rx_float = is_repeater && !pins_s.port_output_enable;

  // transmit-ready pin: test data, gated permit, or free
  wire next_tx_ready = in_test ? core_in.test_out_data :
                       (rate_gate ? core_in.rate_permit : 1'b1);

  // test ports reuse the address straps live
  wire next_test_in = in_test && pins_s.phy_addr[4];
  wire next_test_exec = in_test && pins_s.phy_addr[1];
  wire next_test_clk = in_test && pins_s.phy_addr[0];

  wire [4:0] next_addr = is_repeater ? cfg.phy_addr : 5'h00;
  wire next_force_fast = is_repeater && cfg.force_fast_speed;
  wire next_autoneg_en = !(is_repeater && cfg.autoneg_disable);
  wire next_cong = is_adapter && rate_gate && core_in.duplex_full &&
                   pins_s.rx_congestion;

  // leds, blanked by software; duplex pin level not blanked
  wire next_act = !led_blank && (core_in.tx_active || core_in.rx_active);
  wire next_link = !led_blank && core_in.link_valid;
  wire next_speed = !led_blank && core_in.speed_fast;
  wire next_fdx_low = !core_in.duplex_full;

  ////////////////////////////////////////////////////////////////////////////////
  // registered pin outputs

  always_ff @(posedge core_clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      rx_output_enable_n_out <= 1'b1;
      tx_ready_gate_out <= 1'b0;
      test_in_out <= 1'b0;
      test_exec_out <= 1'b0;
      test_clk_out <= 1'b0;
      phy_address_out <= 5'h00;
      force_speed_fast_out <= 1'b0;
      autoneg_enable_out <= 1'b1;
    end else begin
      rx_output_enable_n_out <= rx_float;
      tx_ready_gate_out <= next_tx_ready;
      test_in_out <= next_test_in;
      test_exec_out <= next_test_exec;
      test_clk_out <= next_test_clk;
      phy_address_out <= next_addr;
      force_speed_fast_out <= next_force_fast;
      autoneg_enable_out <= next_autoneg_en;
    end
  end

  // configuration and handshake outputs
  always_ff @(posedge core_clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      mac_flavour_select_out <= 1'b0;
      combo_mode_out <= 1'b0;
      slave_tristate_out <= 1'b0;
      slave_tristate_oe_n_out <= 1'b1;
      slave_link_ok_out <= 1'b0;
      scramble_bypass_out <= 1'b0;
      loopback_en_out <= 1'b0;
      advertise_full_duplex_out <= 1'b0;
      rate_gate_enable_out <= 1'b0;
      rx_congestion_out <= 1'b0;
    end else begin
      mac_flavour_select_out <= mac_flavour;
      combo_mode_out <= combo;
      slave_tristate_out <= combo;
      slave_tristate_oe_n_out <= !combo;
      slave_link_ok_out <= slave_link;
      scramble_bypass_out <= pins_s.scramble_bypass;
      loopback_en_out <= pins_s.loopback_en;
      advertise_full_duplex_out <= adv_fdx;
      rate_gate_enable_out <= rate_gate;
      rx_congestion_out <= next_cong;
    end
  end

  // duplex pin and leds
  always_ff @(posedge core_clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      full_duplex_low_out <= 1'b1;
      full_duplex_low_oe_n_out <= 1'b1;
      activity_led_out <= 1'b0;
      link_led_out <= 1'b0;
      speed_led_a_out <= 1'b0;
    end else begin
      full_duplex_low_out <= next_fdx_low;
      full_duplex_low_oe_n_out <= is_repeater;
      activity_led_out <= next_act;
      link_led_out <= next_link;
      speed_led_a_out <= next_speed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // avalon-mm slave, one wait cycle per access

  logic ack;
  wire bus_req = avs_req_in.read || avs_req_in.write;
  wire next_ack = bus_req && !ack;
  wire wr_fire = avs_req_in.write && ack;
  wire ctrl_hit = avs_req_in.address == CTRL_OFFSET;
  assign avs_waitrequest_out = bus_req && !ack;

  logic [31:0] status_word;
  logic [31:0] led_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_MODE_LSB +: 2] = mode;
    status_word[STAT_ADDR_LSB +: 5] = cfg.phy_addr;
    status_word[STAT_FORCE_FAST_BIT] = force_speed_fast_out;
    status_word[STAT_AUTONEG_EN_BIT] = autoneg_enable_out;
    status_word[STAT_COMBO_BIT] = combo_mode_out;
    status_word[STAT_SLAVE_LINK_BIT] = slave_link_ok_out;
    status_word[STAT_SCRAMBLE_BYP_BIT] = scramble_bypass_out;
    status_word[STAT_LOOPBACK_BIT] = loopback_en_out;
    status_word[STAT_RATE_GATE_BIT] = rate_gate_enable_out;
    status_word[STAT_MAC_FLAVOUR_BIT] = mac_flavour_select_out;
    led_word = 32'h0000_0000;
    led_word[LED_ACT_BIT] = activity_led_out;
    led_word[LED_LINK_BIT] = link_led_out;
    led_word[LED_SPEED_BIT] = speed_led_a_out;
    led_word[LED_FDX_LOW_BIT] = full_duplex_low_out;
  end

  // read selection, unmapped reads zero
  wire [31:0] rd_mux = ctrl_hit ? {30'h0, ctrl} :
      (avs_req_in.address == STATUS_OFFSET) ? status_word :
      (avs_req_in.address == LED_OFFSET) ? led_word : 32'h0000_0000;

  always_ff @(posedge core_clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      ack <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
      ctrl <= CTRL_RESET;
    end else begin
      ack <= next_ack;
      if (next_ack && avs_req_in.read) begin
        avs_readdata_out <= rd_mux;
      end
      if (wr_fire && ctrl_hit && avs_req_in.byteenable[0]) begin
        ctrl <= avs_req_in.writedata[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!core_rst_n);

  reset_stretch_a: assert property (@(posedge core_clk_in) disable iff (!reset_sync_n)
    $rose(reset_sync_n) |-> !core_rst_n [*8])
    else $error("core reset released too early");
  rx_tristate_a: assert property (rx_float |=> rx_output_enable_n_out)
    else $error("receive outputs not floated");
  test_tx_mux_a: assert property (in_test |=> tx_ready_gate_out == $past(core_in.test_out_data))
    else $error("test output not on transmit-ready pin");
  test_route_a: assert property (in_test |=> test_in_out == $past(pins_s.phy_addr[4]) &&
    test_clk_out == $past(pins_s.phy_addr[0]) && test_exec_out == $past(pins_s.phy_addr[1]))
    else $error("test inputs misrouted");
  phy_addr_a: assert property (is_repeater |=> phy_address_out == $past(cfg.phy_addr))
    else $error("management address not from straps");
  autoneg_dis_a: assert property ((is_repeater && cfg.autoneg_disable) |=> !autoneg_enable_out)
    else $error("auto-negotiation not disabled");
  slave_tri_a: assert property (combo |=> slave_tristate_out && !slave_tristate_oe_n_out)
    else $error("slave tristate not driven active");
  fdx_drive_a: assert property (is_adapter |=> !full_duplex_low_oe_n_out &&
    full_duplex_low_out == !$past(core_in.duplex_full))
    else $error("duplex pin not driven");
  rate_gate_a: assert property ((rate_gate && !in_test) |=>
    tx_ready_gate_out == $past(core_in.rate_permit))
    else $error("transmit ready ignores permit");
  act_led_a: assert property ((!led_blank && core_in.tx_active) |=> activity_led_out)
    else $error("activity led off during activity");
  cfg_reload_a: assert property ($changed(pins_s.repeater_select) |=>
    cfg.repeater_select == $past(pins_s.repeater_select))
    else $error("mode change not reloaded");

  repeater_float_c: cover property (rx_float ##1 rx_output_enable_n_out);
  combo_mode_c: cover property (combo ##1 slave_link_ok_out);
  test_mode_c: cover property (in_test ##1 test_exec_out);
  ctrl_write_c: cover property (wr_fire && ctrl_hit);

endmodule

// File: tb/psmlc_partner.sv
// far-side model: mac or repeater controller plus optional slave phy
`timescale 1ns/1ps
module psmlc_partner (
  input wire logic fdx_low_in,
  input wire logic fdx_oe_n_in,
  input wire logic slave_tri_in,
  input wire logic slave_tri_oe_n_in,
  input wire logic advertise_fd_in,
  input wire logic slave_link_good_in,
  input wire logic overrun_in,
  output logic fdx_pin_out,
  output logic slave_link_pin_out,
  output logic congestion_out,
  output logic slave_float_out
);
  ////////////////////////////////////////////////////////////////////////////////
  // duplex pin: block drives it, else controller advertises with a low level
  assign fdx_pin_out = fdx_oe_n_in ? ~advertise_fd_in : fdx_low_in;
  // slave link status, low while slave link is good
  assign slave_link_pin_out = ~slave_link_good_in;
  // slave floats its outputs while the tristate request is driven active
  assign slave_float_out = slave_tri_in & ~slave_tri_oe_n_in;
  // controller overrun report
  assign congestion_out = overrun_in;
endmodule

// File: tb/phy_strap_mode_and_led_control_test.sv
// self-checking bench of the strap, pin-mux and led block
`timescale 1ns/1ps
module phy_strap_mode_and_led_control_test;
  import psmlc_pkg::*;
  logic clk, rst_n, adv_fd, slave_link, cong, fdx_pin, link_pin, cong_pin, slave_float;
  psmlc_pins_type pins, pins_w;
  psmlc_core_type core;
  psmlc_avs_req_type req;
  logic avs_waitrequest_out, rx_output_enable_n_out, tx_ready_gate_out, test_in_out;
  logic test_exec_out, test_clk_out, force_speed_fast_out, autoneg_enable_out;
  logic mac_flavour_select_out, combo_mode_out, slave_tristate_out, slave_tristate_oe_n_out;
  logic slave_link_ok_out, scramble_bypass_out, loopback_en_out, advertise_full_duplex_out;
  logic rate_gate_enable_out, rx_congestion_out, full_duplex_low_out, full_duplex_low_oe_n_out;
  logic activity_led_out, link_led_out, speed_led_a_out;
  logic [31:0] avs_readdata_out;
  logic [4:0] phy_address_out;
  logic [15:0] lfsr;
  logic [63:0] exp_q[$];
  int err_count, n_checks;

  ////////////////////////////////////////////////////////////////////////////////
  // clock and design
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // partner pins merged into the pin bundle
  always_comb begin
    pins_w = pins;
    pins_w.full_duplex_low = fdx_pin;
    pins_w.rx_congestion = cong_pin;
    if (!pins.repeater_select) pins_w.phy_addr[2] = link_pin;
  end
  psmlc_top uut (.core_clk_in(clk), .reset_n_in(rst_n), .pins_in(pins_w), .core_in(core),
    .avs_req_in(req), .avs_waitrequest_out(avs_waitrequest_out),
    .avs_readdata_out(avs_readdata_out), .rx_output_enable_n_out(rx_output_enable_n_out),
    .tx_ready_gate_out(tx_ready_gate_out), .test_in_out(test_in_out),
    .test_exec_out(test_exec_out), .test_clk_out(test_clk_out),
    .phy_address_out(phy_address_out), .force_speed_fast_out(force_speed_fast_out),
    .autoneg_enable_out(autoneg_enable_out), .mac_flavour_select_out(mac_flavour_select_out),
    .combo_mode_out(combo_mode_out), .slave_tristate_out(slave_tristate_out),
    .slave_tristate_oe_n_out(slave_tristate_oe_n_out), .slave_link_ok_out(slave_link_ok_out),
    .scramble_bypass_out(scramble_bypass_out), .loopback_en_out(loopback_en_out),
    .advertise_full_duplex_out(advertise_full_duplex_out),
    .rate_gate_enable_out(rate_gate_enable_out), .rx_congestion_out(rx_congestion_out),
    .full_duplex_low_out(full_duplex_low_out),
    .full_duplex_low_oe_n_out(full_duplex_low_oe_n_out), .activity_led_out(activity_led_out),
    .link_led_out(link_led_out), .speed_led_a_out(speed_led_a_out));
  psmlc_partner partner (.fdx_low_in(full_duplex_low_out), .fdx_oe_n_in(full_duplex_low_oe_n_out),
    .slave_tri_in(slave_tristate_out), .slave_tri_oe_n_in(slave_tristate_oe_n_out),
    .advertise_fd_in(adv_fd), .slave_link_good_in(slave_link), .overrun_in(cong),
    .fdx_pin_out(fdx_pin), .slave_link_pin_out(link_pin), .congestion_out(cong_pin),
    .slave_float_out(slave_float));

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  // one avalon cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    req.read <= ~wr;
    req.write <= wr;
    req.address <= a;
    req.byteenable <= 4'hf;
    req.writedata <= d;
    // no own limit: only the watchdog ends a wait that never answers
    do begin
      @(posedge clk);
    end while (avs_waitrequest_out !== 1'b0);
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] mask);
    exp_q.push_back({mask, exp});
    bus(1'b0, a, 32'h0);
  endtask
  // read data compared at the edge that ends each read
  always @(posedge clk) begin
    logic [63:0] e;
    if (req.read === 1'b1 && avs_waitrequest_out === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check(avs_readdata_out & e[63:32], e[31:0]);
    end
  end
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    tick(20000);
    err_count++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  initial begin
    rst_n = 0;
    pins = '0;
    core = '0;
    req = '0;
    adv_fd = 0;
    slave_link = 0;
    cong = 0;
    lfsr = 16'hb9e6;
    err_count = 0;
    n_checks = 0;
    tick(16);
    rst_n <= 1'b1;
    tick(30);
    rd(CTRL_OFFSET, 32'h2, 32'hffffffff);
    bus(1'b1, 4'hc, 32'hffffffff);
    rd(4'hc, 32'h0, 32'hffffffff);
    // repeater straps loaded on mode change, then held
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      pins.phy_addr <= lfsr[4:0];
      pins.force_fast_speed <= lfsr[5];
      pins.autoneg_disable <= lfsr[6];
      pins.port_output_enable <= lfsr[7];
      pins.repeater_select <= 1'b1;
      tick(8);
      check(32'(phy_address_out), 32'(lfsr[4:0]));
      check(32'(force_speed_fast_out), 32'(lfsr[5]));
      check(32'(autoneg_enable_out), 32'(!lfsr[6]));
      check(32'(rx_output_enable_n_out), 32'(!lfsr[7]));
      rd(STATUS_OFFSET, {23'h0, lfsr[4:0], 2'h0, PSMLC_MODE_REPEATER}, 32'h1f3);
      pins.phy_addr <= ~lfsr[4:0];
      tick(8);
      check(32'(phy_address_out), 32'(lfsr[4:0]));
      pins.repeater_select <= 1'b0;
      tick(8);
    end
    // repeater rate gating from advertised duplex
    pins.repeater_select <= 1'b1;
    core.hcd_tx_fd <= 1'b1;
    adv_fd <= 1'b1;
    tick(8);
    check(32'(full_duplex_low_oe_n_out), 32'h1);
    check(32'(advertise_full_duplex_out), 32'h1);
    check(32'(rate_gate_enable_out), 32'h1);
    for (int p = 0; p < 2; p++) begin
      core.rate_permit <= p[0];
      tick(2);
      check(32'(tx_ready_gate_out), 32'(p[0]));
    end
    adv_fd <= 1'b0;
    core.rate_permit <= 1'b0;
    tick(8);
    check(32'(rate_gate_enable_out), 32'h0);
    check(32'(tx_ready_gate_out), 32'h1);
    // test mode pin reuse
    pins.test_enable <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      pins.phy_addr <= lfsr[4:0];
      core.test_out_data <= lfsr[5];
      tick(8);
      check(32'(test_in_out), 32'(lfsr[4]));
      check(32'(test_exec_out), 32'(lfsr[1]));
      check(32'(test_clk_out), 32'(lfsr[0]));
      check(32'(tx_ready_gate_out), 32'(lfsr[5]));
    end
    rd(STATUS_OFFSET, 32'(PSMLC_MODE_TEST), 32'h3);
    // adapter combo with slave phy
    pins.test_enable <= 1'b0;
    pins.repeater_select <= 1'b0;
    pins.autoneg_disable <= 1'b1;
    pins.force_fast_speed <= 1'b1;
    core.duplex_full <= 1'b1;
    tick(8);
    check(32'(combo_mode_out), 32'h1);
    check({slave_tristate_out, slave_tristate_oe_n_out, slave_float}, 32'h5);
    check({full_duplex_low_out, full_duplex_low_oe_n_out}, 32'h0);
    check(32'(mac_flavour_select_out), 32'h1);
    for (int b = 0; b < 2; b++) begin
      slave_link <= b[0];
      cong <= b[0];
      tick(8);
      check(32'(slave_link_ok_out), 32'(b[0]));
      check(32'(rx_congestion_out), 32'(b[0]));
    end
    // live bypass and loopback pins
    for (int i = 0; i < 4; i++) begin
      pins.scramble_bypass <= i[0];
      pins.loopback_en <= i[1];
      tick(6);
      check(32'(scramble_bypass_out), 32'(i[0]));
      check(32'(loopback_en_out), 32'(i[1]));
    end
    // leds from datapath status
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      core.tx_active <= lfsr[0];
      core.rx_active <= lfsr[1];
      core.link_valid <= lfsr[2];
      core.speed_fast <= lfsr[3];
      tick(2);
      check(32'(activity_led_out), 32'(lfsr[0] | lfsr[1]));
      check(32'(link_led_out), 32'(lfsr[2]));
      check(32'(speed_led_a_out), 32'(lfsr[3]));
      rd(LED_OFFSET, {29'h0, lfsr[3], lfsr[2], lfsr[0] | lfsr[1]}, 32'h7);
    end
    // blanking and software rate gate off
    core.tx_active <= 1'b1;
    bus(1'b1, CTRL_OFFSET, 32'h1);
    tick(3);
    check({activity_led_out, link_led_out, speed_led_a_out, rate_gate_enable_out}, 32'h0);
    rd(CTRL_OFFSET, 32'h1, 32'hffffffff);
    // reset in mid-run
    rst_n <= 1'b0;
    tick(20);
    check({rx_output_enable_n_out, full_duplex_low_out, slave_tristate_oe_n_out}, 32'h7);
    rst_n <= 1'b1;
    tick(30);
    rd(CTRL_OFFSET, 32'h2, 32'hffffffff);
    tick(2);
    finish_test();
  end
endmodule
